// >>> src/hmba_arbiter.v
// Purpose: Harvard memory bus arbiter, one grant per target per cycle
// Assumes: Core requests on sys_clk; each request names its target
// Notes:   Grants registered; a losing request waits, held by the core
`timescale 1ns/1ps
`default_nettype none
`include "hmba_map.vh"

// Summary of operation
// - Three independent buses: program read, data read, write
// - Program read bus: 22 address, 32 data
// - Data read/write buses: 32 address, 32 data
// - 32-bit data transfer in one cycle
// - Fetch, read, write together if targets differ
// - Each target has its own priority logic
// - Priority: data-write, program-write, data-read, program-read, fetch
module hmba_arbiter #(
    parameter NTGT = 4
) (
    input  wire                     sys_clk,
    input  wire                     reset,
    // Requests, each with a one-hot target select
    input  wire                     dwr_req,
    input  wire [NTGT-1:0]          dwr_sel,
    input  wire [`HMBA_DADDR_W-1:0] dwr_addr,
    input  wire [`HMBA_DATA_W-1:0]  dwr_data,
    input  wire                     pwr_req,
    input  wire [NTGT-1:0]          pwr_sel,
    input  wire [`HMBA_PADDR_W-1:0] pwr_addr,
    input  wire [`HMBA_DATA_W-1:0]  pwr_data,
    input  wire                     drd_req,
    input  wire [NTGT-1:0]          drd_sel,
    input  wire [`HMBA_DADDR_W-1:0] drd_addr,
    input  wire                     prd_req,
    input  wire [NTGT-1:0]          prd_sel,
    input  wire [`HMBA_PADDR_W-1:0] prd_addr,
    input  wire                     fet_req,
    input  wire [NTGT-1:0]          fet_sel,
    input  wire [`HMBA_PADDR_W-1:0] fet_addr,
    // Per-request completion, one-cycle pulses; wait flags held while the request loses
    output reg                      dwr_done,
    output reg                      pwr_done,
    output reg                      drd_done,
    output reg                      prd_done,
    output reg                      fet_done,
    output reg                      drd_wait,
    output reg                      prd_wait,
    output reg                      fet_wait,
    output reg                      dwr_wait,
    output reg                      pwr_wait,
    // Read data back to the core
    input  wire [NTGT*`HMBA_DATA_W-1:0] tgt_rdata,
    output reg  [`HMBA_DATA_W-1:0]  drd_rdata,
    output reg  [`HMBA_DATA_W-1:0]  prg_rdata,
    // Per-target access, registered
    output reg  [NTGT-1:0]          tgt_en,
    output reg  [NTGT-1:0]          tgt_we,
    output reg  [NTGT*`HMBA_DADDR_W-1:0] tgt_addr,
    output reg  [NTGT*`HMBA_DATA_W-1:0]  tgt_wdata
);
    // =========================================================
    // Per-target arbitration
    // =========================================================
    wire [NTGT*`HMBA_NREQ-1:0]    g_flat;     // One grant field per target
    wire [NTGT-1:0]               en_next;
    wire [NTGT-1:0]               we_next;
    wire [NTGT*`HMBA_DADDR_W-1:0] addr_next;
    wire [NTGT*`HMBA_DATA_W-1:0]  wdata_next;
    wire                          won_dwr;
    wire                          won_pwr;
    wire                          won_drd;
    wire                          won_prd;
    wire                          won_fet;
    reg  [`HMBA_NREQ-1:0]         won;
    reg  [`HMBA_NREQ-1:0]         won_reg;
    reg  [NTGT-1:0]               dsrc_reg;   // Targets whose data read is due
    reg  [NTGT-1:0]               psrc_reg;   // Targets whose program read is due
    reg  [`HMBA_DATA_W-1:0]       drd_next;
    reg  [`HMBA_DATA_W-1:0]       prg_next;
    integer                       j;
    integer                       m;

    genvar t;
    generate
        for (t = 0; t < NTGT; t = t + 1) begin : g_tgt
            wire [`HMBA_NREQ-1:0] r;
            wire [`HMBA_NREQ-1:0] gnt;
            // Bit order is grant order, data write at bit 0
            // Each target decides alone, so disjoint targets all complete, except that a fetch won with a program read gets no word
            assign r = {fet_req & fet_sel[t], prd_req & prd_sel[t],
                        drd_req & drd_sel[t], pwr_req & pwr_sel[t],
                        dwr_req & dwr_sel[t]};
            hmba_prio i_hmba_prio (
                .req   (r),
                .grant (gnt)
            );
            assign g_flat[t*`HMBA_NREQ +: `HMBA_NREQ] = gnt;
            assign en_next[t] = |gnt;
            assign we_next[t] = gnt[`HMBA_G_DWR] | gnt[`HMBA_G_PWR];
            // Program-side addresses widened with zeros
            assign addr_next[t*`HMBA_DADDR_W +: `HMBA_DADDR_W] =
                gnt[`HMBA_G_DWR] ? dwr_addr :
                gnt[`HMBA_G_PWR] ? {{(`HMBA_DADDR_W-`HMBA_PADDR_W){1'b0}}, pwr_addr} :
                gnt[`HMBA_G_DRD] ? drd_addr :
                gnt[`HMBA_G_PRD] ? {{(`HMBA_DADDR_W-`HMBA_PADDR_W){1'b0}}, prd_addr} :
                gnt[`HMBA_G_FET] ? {{(`HMBA_DADDR_W-`HMBA_PADDR_W){1'b0}}, fet_addr} :
                tgt_addr[t*`HMBA_DADDR_W +: `HMBA_DADDR_W];
            // A read leaves the last written word standing
            assign wdata_next[t*`HMBA_DATA_W +: `HMBA_DATA_W] =
                gnt[`HMBA_G_DWR] ? dwr_data :
                gnt[`HMBA_G_PWR] ? pwr_data :
                tgt_wdata[t*`HMBA_DATA_W +: `HMBA_DATA_W];
        end
    endgenerate

    // =========================================================
    // Target access registers
    // =========================================================
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tgt_en    <= {NTGT{1'b0}};
            tgt_we    <= {NTGT{1'b0}};
            tgt_addr  <= {(NTGT*`HMBA_DADDR_W){1'b0}};
            tgt_wdata <= {(NTGT*`HMBA_DATA_W){1'b0}};
        end else begin
            tgt_en    <= en_next;
            tgt_we    <= we_next;
            // Whole 32-bit word per access, no splitting
            tgt_addr  <= addr_next;
            tgt_wdata <= wdata_next;
        end
    end

    // =========================================================
    // Collect grants per requester
    // =========================================================
    always @* begin
        won = {`HMBA_NREQ{1'b0}};
        for (j = 0; j < NTGT; j = j + 1)
            won = won | g_flat[j*`HMBA_NREQ +: `HMBA_NREQ];
    end

    assign won_dwr = won[`HMBA_G_DWR];
    assign won_pwr = won[`HMBA_G_PWR];
    assign won_drd = won[`HMBA_G_DRD];
    assign won_prd = won[`HMBA_G_PRD];
    assign won_fet = won[`HMBA_G_FET];

    // =========================================================
    // Write completion and wait
    // =========================================================
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dwr_done <= 1'b0;
            pwr_done <= 1'b0;
            dwr_wait <= 1'b0;
            pwr_wait <= 1'b0;
            drd_wait <= 1'b0;
            prd_wait <= 1'b0;
            fet_wait <= 1'b0;
        end else begin
            // A write ends together with its strobe
            dwr_done <= won_dwr;
            pwr_done <= won_pwr;
            // Losers wait; the core holds address and data meanwhile
            dwr_wait <= dwr_req & ~won_dwr;
            pwr_wait <= pwr_req & ~won_pwr;
            drd_wait <= drd_req & ~won_drd;
            prd_wait <= prd_req & ~won_prd;
            fet_wait <= fet_req & ~won_fet;
        end
    end

    // =========================================================
    // Read-data selection
    // =========================================================
    always @* begin
        drd_next = drd_rdata;
        prg_next = prg_rdata;
        for (m = 0; m < NTGT; m = m + 1) begin
            if (dsrc_reg[m])
                drd_next = tgt_rdata[m*`HMBA_DATA_W +: `HMBA_DATA_W];
            if (psrc_reg[m])
                prg_next = tgt_rdata[m*`HMBA_DATA_W +: `HMBA_DATA_W];
        end
    end

    // =========================================================
    // Read-data return
    // =========================================================
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            won_reg   <= `HMBA_GRANT_RST;
            dsrc_reg  <= {NTGT{1'b0}};
            psrc_reg  <= {NTGT{1'b0}};
            drd_done  <= 1'b0;
            prd_done  <= 1'b0;
            fet_done  <= 1'b0;
            drd_rdata <= `HMBA_WORD_RST;
            prg_rdata <= `HMBA_WORD_RST;
        end else begin
            won_reg  <= won;
            dsrc_reg <= {NTGT{won_drd}} & drd_sel;
            // Program read and fetch share one return path; program read takes it when both win
            psrc_reg <= {NTGT{won_prd | won_fet}} &
                        (won_prd ? prd_sel : fet_sel);
            // Word taken the cycle after the strobe; separate data and
            // program read buses
            drd_done  <= won_reg[`HMBA_G_DRD];
            prd_done  <= won_reg[`HMBA_G_PRD];
            fet_done  <= won_reg[`HMBA_G_FET];
            drd_rdata <= drd_next;
            prg_rdata <= prg_next;
        end
    end
endmodule // hmba_arbiter

`default_nettype wire

// >>> src/hmba_map.vh
// Purpose: Constants for the memory bus arbiter
// Assumes: Plain Verilog-2005 includer
// Notes:   Widths and grant codes shared by both design files
`ifndef HMBA_MAP_VH
`define HMBA_MAP_VH

`define HMBA_PADDR_W     22
`define HMBA_DADDR_W     32
`define HMBA_DATA_W      32
`define HMBA_NREQ        5
// Grant index, highest priority first
`define HMBA_G_DWR       0
`define HMBA_G_PWR       1
`define HMBA_G_DRD       2
`define HMBA_G_PRD       3
`define HMBA_G_FET       4
`define HMBA_GRANT_RST   5'h00
`define HMBA_WORD_RST    32'h0000_0000

`endif

// >>> src/hmba_prio.v
// Purpose: Fixed priority picker for one target
// Assumes: Requests from the same clock domain
// Notes:   Lowest index wins
`timescale 1ns/1ps
`default_nettype none
`include "hmba_map.vh"

module hmba_prio (
    input  wire [`HMBA_NREQ-1:0] req,
    output reg  [`HMBA_NREQ-1:0] grant
);
    integer i;
    reg     found;

    always @* begin
        grant = {`HMBA_NREQ{1'b0}};
        found = 1'b0;
        for (i = 0; i < `HMBA_NREQ; i = i + 1) begin
            if (req[i] && !found) begin
                grant[i] = 1'b1;
                found    = 1'b1;
            end
        end
    end
endmodule // hmba_prio

`default_nettype wire

// >>> verification/harvard_memory_bus_arbiter_tb_top.sv
// Purpose: Self-checking bench for the arbiter
// Assumes: Core side driven here, one request kind each
// Notes:   Grant seen as wait low after a request edge
`timescale 1ns/1ps
`default_nettype none
module harvard_memory_bus_arbiter_tb_top;
    logic sys_clk = 0, reset = 1;
    logic [4:0] req = 0;
    logic [19:0] s = 0;
    logic [31:0] ad [5] = '{32'hC0DE_0004, 32'h0012_3458, 32'hBEEF_000C, 32'h003F_FFFC, 32'h0000_0010};
    wire [4:0] dn, wt;
    wire [3:0] en, we;
    wire [127:0] ta, tw, trd;
    wire [31:0] drd_rdata, prg_rdata;
    int fails = 0, n_compared = 0, cyc = 0;
    always #10 sys_clk = ~sys_clk;
    hmba_arbiter i_hmba_arbiter (.sys_clk(sys_clk), .reset(reset),
        .dwr_req(req[0]), .dwr_sel(s[3:0]), .dwr_addr(ad[0]), .dwr_data(~ad[0]),
        .pwr_req(req[1]), .pwr_sel(s[7:4]), .pwr_addr(ad[1][21:0]), .pwr_data(~ad[1]),
        .drd_req(req[2]), .drd_sel(s[11:8]), .drd_addr(ad[2]),
        .prd_req(req[3]), .prd_sel(s[15:12]), .prd_addr(ad[3][21:0]),
        .fet_req(req[4]), .fet_sel(s[19:16]), .fet_addr(ad[4][21:0]),
        .dwr_done(dn[0]), .pwr_done(dn[1]), .drd_done(dn[2]), .prd_done(dn[3]), .fet_done(dn[4]),
        .dwr_wait(wt[0]), .pwr_wait(wt[1]), .drd_wait(wt[2]), .prd_wait(wt[3]), .fet_wait(wt[4]),
        .tgt_rdata(trd), .drd_rdata(drd_rdata), .prg_rdata(prg_rdata),
        .tgt_en(en), .tgt_we(we), .tgt_addr(ta), .tgt_wdata(tw));
    hmba_tgt_model i_hmba_tgt_model (.sys_clk(sys_clk), .tgt_en(en), .tgt_addr(ta), .tgt_rdata(trd));
    task chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(string nm, logic [4:0] m, logic [19:0] sl, logic [14:0] ex);
        int k, t;
        logic [4:0] pend, lastg;
        s = sl;
        req = m;
        pend = m;
        lastg = 0;
        k = 0;
        while ((pend | lastg) != 0 && k < 9) begin
            @(posedge sys_clk);
            #1;
            k++;
            for (int i = 2; i < 5; i++) if (lastg[i]) begin
                chk("read done", 1, dn[i]);
                chk("read data", ad[i] ^ 32'h5A5A_5A5A, i == 2 ? drd_rdata : prg_rdata);
            end
            lastg = 0;
            for (int i = 0; i < 5; i++) if (pend[i] && !wt[i]) begin
                pend[i] = 0;
                req[i] = 0;
                lastg[i] = i > 1;
                t = s[4*i+1] + 2 * s[4*i+2] + 3 * s[4*i+3];
                chk("grant cycle", ex[3*i+:3], k);
                chk("strobe", 1, en[t]);
                chk("address", ad[i], ta[32*t+:32]);
                chk("write kind", i < 2, we[t]);
                if (i < 2) chk("write data", ~ad[i], tw[32*t+:32]);
                if (i < 2) chk("write done", 1, dn[i]);
            end
        end
        chk("all served", 0, pend | lastg);
        @(posedge sys_clk);
        #1;
        $display("test %s finished", nm);
    endtask
    task t_same_tgt; run("same_tgt", 5'b10101, 20'h1_1111, {3'd3, 3'd0, 3'd2, 3'd0, 3'd1}); endtask
    task t_prog_wr; run("prog_wr", 5'b01110, 20'h4_4444, {3'd0, 3'd3, 3'd2, 3'd1, 3'd0}); endtask
    task t_parallel; run("parallel", 5'b10101, 20'h1_1214, {3'd1, 3'd0, 3'd1, 3'd0, 3'd1}); endtask
    task t_mixed; run("mixed", 5'b01110, 20'h1_2881, {3'd0, 3'd1, 3'd2, 3'd1, 3'd0}); endtask
    task t_reset;
        s = 20'h1_1214;
        req = 5'b10101;
        @(posedge sys_clk);
        #1 reset = 1;
        req = 0;
        #1;
        chk("strobe in reset", 0, en);
        chk("done in reset", 0, dn);
        chk("wait in reset", 0, wt);
        chk("read data in reset", 0, drd_rdata);
        @(posedge sys_clk);
        #1 reset = 0;
        $display("test reset finished");
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 reset = 0;
        t_same_tgt();
        t_prog_wr();
        t_parallel();
        t_mixed();
        t_reset();
        t_parallel();
        end_sim();
    end
endmodule // harvard_memory_bus_arbiter_tb_top
`default_nettype wire

// >>> verification/hmba_props_properties.sv
// Purpose: Port checks for the arbiter
// Assumes: One clock domain
// Notes:   Grant order per shared target
`timescale 1ns/1ps
`default_nettype none
module hmba_props #(parameter int NTGT = 4) (
    input wire logic            sys_clk,
    input wire logic            reset,
    input wire logic            dwr_req,
    input wire logic            pwr_req,
    input wire logic            drd_req,
    input wire logic            prd_req,
    input wire logic            fet_req,
    input wire logic [NTGT-1:0] dwr_sel,
    input wire logic [NTGT-1:0] pwr_sel,
    input wire logic [NTGT-1:0] drd_sel,
    input wire logic [NTGT-1:0] prd_sel,
    input wire logic [NTGT-1:0] fet_sel,
    input wire logic            dwr_wait,
    input wire logic            drd_wait,
    input wire logic            prd_wait,
    input wire logic            fet_wait,
    input wire logic            dwr_done,
    input wire logic            drd_done,
    input wire logic [NTGT-1:0] tgt_en,
    input wire logic [NTGT-1:0] tgt_we
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_dwr_never_waits: assert property (dwr_req |=> !dwr_wait)
        else $error("data write was kept waiting");
    a_dwr_over_drd: assert property (dwr_req && drd_req && dwr_sel == drd_sel |=> drd_wait)
        else $error("data read not held behind data write");
    a_pwr_over_drd: assert property (pwr_req && drd_req && pwr_sel == drd_sel |=> drd_wait)
        else $error("data read not held behind program write");
    a_drd_over_prd: assert property (drd_req && prd_req && drd_sel == prd_sel |=> prd_wait)
        else $error("program read not held behind data read");
    a_drd_over_fet: assert property (drd_req && fet_req && drd_sel == fet_sel |=> fet_wait)
        else $error("fetch not held behind data read");
    a_parallel_grant: assert property (dwr_req && drd_req && fet_req && !pwr_req && !prd_req
        && (dwr_sel & drd_sel) == 0 && (dwr_sel & fet_sel) == 0 && (drd_sel & fet_sel) == 0
        |=> !drd_wait && !fet_wait && tgt_en == $past(dwr_sel | drd_sel | fet_sel))
        else $error("disjoint accesses not served together");
    a_write_strobe: assert property (dwr_done |-> (tgt_en & tgt_we) != 0)
        else $error("write done without write strobe");
    a_read_latency: assert property (drd_done |-> ($past(tgt_en) & ~$past(tgt_we)) != 0)
        else $error("read done without read strobe before");
    a_idle_quiet: assert property (!(dwr_req | pwr_req | drd_req | prd_req | fet_req)
        |=> tgt_en == 0) else $error("strobe with no request");
endmodule // hmba_props
bind hmba_arbiter hmba_props #(.NTGT(NTGT)) i_hmba_props (.sys_clk(sys_clk), .reset(reset),
    .dwr_req(dwr_req), .pwr_req(pwr_req), .drd_req(drd_req), .prd_req(prd_req),
    .fet_req(fet_req), .dwr_sel(dwr_sel), .pwr_sel(pwr_sel), .drd_sel(drd_sel),
    .prd_sel(prd_sel), .fet_sel(fet_sel), .dwr_wait(dwr_wait), .drd_wait(drd_wait),
    .prd_wait(prd_wait), .fet_wait(fet_wait), .dwr_done(dwr_done), .drd_done(drd_done),
    .tgt_en(tgt_en), .tgt_we(tgt_we));
`default_nettype wire

// >>> verification/hmba_tgt_model.sv
// Purpose: Memory side model, read word from address
// Assumes: Word sampled the edge ending the strobe
// Notes:   Stale word inverted so a sample two or more edges late fails
`timescale 1ns/1ps
`default_nettype none
module hmba_tgt_model #(parameter int NTGT = 4) (
    input  wire logic               sys_clk,
    input  wire logic [NTGT-1:0]    tgt_en,
    input  wire logic [NTGT*32-1:0] tgt_addr,
    output logic      [NTGT*32-1:0] tgt_rdata
);
    logic [31:0]     held_reg [NTGT];
    logic [NTGT-1:0] fresh_reg;
    always @(posedge sys_clk) begin
        fresh_reg <= tgt_en;
        for (int k = 0; k < NTGT; k++)
            if (tgt_en[k]) held_reg[k] <= tgt_addr[32*k+:32] ^ 32'h5A5A_5A5A;
    end
    always_comb
        for (int k = 0; k < NTGT; k++)
            tgt_rdata[32*k+:32] = tgt_en[k] ? tgt_addr[32*k+:32] ^ 32'h5A5A_5A5A
                                : fresh_reg[k] ? held_reg[k] : ~held_reg[k];
endmodule // hmba_tgt_model
`default_nettype wire
